// [verilog/ldi_dev.sv]
// device end: two-wire slave receiving register writes
// assumes: clk_link oversamples the bus; rst_n belongs to clk_sys
`timescale 1ns/1ps
module ldi_dev import ldi_pkg::*; #(
    parameter logic [6:0] OWN_ADDR = LDI_DEF_DEV_ADDR
) (
    // link side
    input logic clk_link,
    ldi_if.device bus,
    // user clock and reset
    input logic clk_sys,
    input logic rst_n,
    // multi-function pin
    input logic pin_input_level,
    input logic mf_is_input,
    // register write results and bus busy flag
    output logic wr_valid,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic pin_data,
    output logic bus_busy
);

    // ---------------- link clock domain ----------------

    logic [2:0] rst_s_reg; // reset carried into link domain
    logic lrst_n_reg; // link-domain reset, low active
    logic [2:0] scl_s_reg; // clock pin synchroniser
    logic [2:0] sda_s_reg; // data pin synchroniser
    logic scl_f_reg; // filtered clock level
    logic sda_f_reg; // filtered data level
    logic scl_p_reg; // previous filtered clock
    logic sda_p_reg; // previous filtered data
    logic scl_rise; // clock edge up
    logic scl_fall; // clock edge down
    logic start_det; // start or repeated start
    logic stop_det; // stop seen
    logic rx_state; // state that shifts a byte in
    logic byte_done; // eighth bit taken, clock went low
    logic addr_hit; // address byte names this device
    ldi_dev_st_e state_reg; // receive state
    ldi_dev_st_e after_reg; // state taken once ack ends
    logic [3:0] bit_cnt_reg; // bits of current byte
    logic [7:0] shift_reg; // incoming byte
    logic sda_oe_n_reg; // low while pulling data low
    logic sda_o_reg; // level driven when enabled
    logic [7:0] reg_sel_reg; // selected register
    logic [7:0] data_byte_reg; // data for selected register
    logic wr_tog_reg; // flips once per committed write
    logic busy_reg; // bus occupied

    // reset crosses with three stages, taken when two agree
    always_ff @(posedge clk_link) begin
        rst_s_reg <= {rst_s_reg[1:0], rst_n};
        lrst_n_reg <= ldi_filt(lrst_n_reg, rst_s_reg[1], rst_s_reg[2]);
    end

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_link) begin
        scl_s_reg <= {scl_s_reg[1:0], bus.scl_line};
        sda_s_reg <= {sda_s_reg[1:0], bus.sda_line};
    end

    // filtered levels and their previous values
    always_ff @(posedge clk_link) begin
        if (!lrst_n_reg) begin
            scl_f_reg <= 1'b1;
            sda_f_reg <= 1'b1;
            scl_p_reg <= 1'b1;
            sda_p_reg <= 1'b1;
        end else begin
            scl_f_reg <= ldi_filt(scl_f_reg, scl_s_reg[1], scl_s_reg[2]);
            sda_f_reg <= ldi_filt(sda_f_reg, sda_s_reg[1], sda_s_reg[2]);
            scl_p_reg <= scl_f_reg;
            sda_p_reg <= sda_f_reg;
        end
    end

    // bus event decode
    always_comb begin
        scl_rise = scl_f_reg & ~scl_p_reg;
        scl_fall = ~scl_f_reg & scl_p_reg;
        start_det = scl_f_reg & scl_p_reg & sda_p_reg & ~sda_f_reg; // [R02]
        stop_det = scl_f_reg & scl_p_reg & ~sda_p_reg & sda_f_reg; // [R03]
        rx_state = (state_reg == LDI_DS_ADDR) ||
                   (state_reg == LDI_DS_REG) ||
                   (state_reg == LDI_DS_DATA);
        byte_done = rx_state & scl_fall & (bit_cnt_reg == LDI_ACK_SLOT);
        addr_hit = (shift_reg[7:1] == OWN_ADDR);
    end

    // receive state machine
    always_ff @(posedge clk_link) begin
        if (!lrst_n_reg) begin
            state_reg <= LDI_DS_IDLE;
        end else if (start_det) begin
            // any start, first or repeated, restarts address
            state_reg <= LDI_DS_ADDR; // [R06]
        end else if (stop_det) begin
            state_reg <= LDI_DS_IDLE;
        end else if (byte_done) begin
            unique case (state_reg)
                // foreign address: sit out the transfer
                LDI_DS_ADDR: state_reg <= addr_hit ? LDI_DS_ACK
                                                   : LDI_DS_SKIP; // [R15]
                default: state_reg <= LDI_DS_ACK;
            endcase
        end else if ((state_reg == LDI_DS_ACK) && scl_fall) begin
            state_reg <= after_reg;
        end
    end

    // where to go once the ack pulse ends
    always_ff @(posedge clk_link) begin
        if (!lrst_n_reg) begin
            after_reg <= LDI_DS_IDLE;
        end else if (byte_done) begin
            unique case (state_reg)
                // read has no data here; ack then stay released
                LDI_DS_ADDR: after_reg <= (shift_reg[0] == LDI_DIR_READ) ?
                                          LDI_DS_SKIP : LDI_DS_REG; // [R11]
                LDI_DS_REG: after_reg <= LDI_DS_DATA; // [R12]
                default: after_reg <= LDI_DS_SKIP;
            endcase
        end
    end

    // bit counter and shifter, msb arrives first
    always_ff @(posedge clk_link) begin
        if (!lrst_n_reg) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (start_det) begin
            bit_cnt_reg <= 4'h0;
        end else if ((state_reg == LDI_DS_ACK) && scl_fall) begin
            bit_cnt_reg <= 4'h0;
        end else if (rx_state && scl_rise &&
                     (bit_cnt_reg != LDI_ACK_SLOT)) begin
            // data sampled on the rising clock, when it is stable
            shift_reg <= {shift_reg[6:0], sda_f_reg}; // [R07] [R01]
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // acknowledge driver; changed after a clock fall, also released on start or stop
    always_ff @(posedge clk_link) begin
        if (!lrst_n_reg) begin
            sda_oe_n_reg <= 1'b1;
            sda_o_reg <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_n_reg <= 1'b1;
        end else if (byte_done) begin
            // pull low across the whole ninth pulse
            sda_oe_n_reg <= (state_reg == LDI_DS_ADDR) ?
                            ~addr_hit : 1'b0; // [R09] [R15] [R01]
        end else if ((state_reg == LDI_DS_ACK) && scl_fall) begin
            sda_oe_n_reg <= 1'b1;
        end
    end

    // capture register select and data, flag a committed write
    always_ff @(posedge clk_link) begin
        if (!lrst_n_reg) begin
            reg_sel_reg <= 8'h00;
            data_byte_reg <= 8'h00;
            wr_tog_reg <= 1'b0;
        end else if (byte_done && (state_reg == LDI_DS_REG)) begin
            reg_sel_reg <= shift_reg; // [R12]
        end else if (byte_done && (state_reg == LDI_DS_DATA)) begin
            // whole byte in hand; commit as the ack begins
            data_byte_reg <= shift_reg; // [R13] [R16]
            wr_tog_reg <= ~wr_tog_reg;
        end
    end

    // bus occupancy
    always_ff @(posedge clk_link) begin
        if (!lrst_n_reg) begin
            busy_reg <= 1'b0;
        end else if (start_det) begin
            busy_reg <= 1'b1; // [R05]
        end else if (stop_det) begin
            busy_reg <= 1'b0; // [R05]
        end
    end

    assign bus.d_sda_oe_n = sda_oe_n_reg;
    assign bus.d_sda_o = sda_o_reg;

    // ---------------- system clock domain ----------------

    logic [2:0] tog_s_reg; // write toggle synchroniser
    logic [2:0] busy_s_reg; // busy level synchroniser
    logic [2:0] pin_s_reg; // pin level synchroniser
    logic pin_f_reg; // filtered pin level
    logic busy_f_reg; // filtered busy level
    logic wr_evt; // one write arrived
    logic wr_valid_reg; // write pulse out
    logic [7:0] wr_addr_reg; // write address out
    logic [7:0] wr_data_reg; // write data out
    logic pin_data_reg; // pin data bit

    // crossing stages; first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        tog_s_reg <= {tog_s_reg[1:0], wr_tog_reg};
        busy_s_reg <= {busy_s_reg[1:0], busy_reg};
        pin_s_reg <= {pin_s_reg[1:0], pin_input_level};
    end

    // toggle edge marks a write; held bytes are stable by now
    assign wr_evt = !rst_n ? 1'b0 : (tog_s_reg[1] ^ tog_s_reg[2]);

    // filtered levels
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_f_reg <= 1'b0;
            busy_f_reg <= 1'b0;
        end else begin
            pin_f_reg <= ldi_filt(pin_f_reg, pin_s_reg[1], pin_s_reg[2]);
            busy_f_reg <= ldi_filt(busy_f_reg, busy_s_reg[1],
                                   busy_s_reg[2]);
        end
    end

    // write results toward the register file
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_valid_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_valid_reg <= wr_evt;
            if (wr_evt) begin
                wr_addr_reg <= reg_sel_reg; // [R13]
                wr_data_reg <= data_byte_reg; // [R13]
            end
        end
    end

    // pin level copied on every write while pin is an input
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_data_reg <= 1'b0;
        end else if (wr_evt && mf_is_input) begin
            pin_data_reg <= pin_f_reg; // [R14]
        end
    end

    assign wr_valid = wr_valid_reg;
    assign wr_addr = wr_addr_reg;
    assign wr_data = wr_data_reg;
    assign pin_data = pin_data_reg;
    assign bus_busy = busy_f_reg;

endmodule

// [verilog/ldi_pkg.sv]
// shared constants, types and helpers of the two-wire led driver link
// assumes: master end on clk_sys, device end on its own link clock
// What this block does
// [R01] data line only changes while clock low
// [R02] data fall with clock high is start
// [R03] data rise with clock high is stop
// [R04] only the master makes start and stop
// [R05] bus busy after start, idle after stop
// [R06] repeated start restarts address reception
// [R07] eight bits per byte, msb first, ack
// [R08] master clocks ack bit, releases data
// [R09] device pulls data low on ninth pulse
// [R10] first byte: seven-bit address plus direction
// [R11] direction bit zero writes, one reads
// [R12] second write byte selects target register
// [R13] third write byte is register's new contents
// [R14] write copies pin level into data bit; here only while mf_is_input is high
// [R15] foreign address: stay released, ignore transfer
// [R16] commit data only after all eight bits
package ldi_pkg;

    // byte and address geometry
    localparam int LDI_BYTE_BITS = 8;
    localparam logic [3:0] LDI_ACK_SLOT = 4'h8;
    localparam logic [1:0] LDI_LAST_BYTE = 2'h2;

    // direction bit values
    localparam logic LDI_DIR_WRITE = 1'b0;
    localparam logic LDI_DIR_READ = 1'b1;

    // device address; value is arbitrary
    localparam logic [6:0] LDI_DEF_DEV_ADDR = 7'h2a;

    // serial clock timing on the master side
    localparam int LDI_CLK_SYS_NS = 8;
    localparam int LDI_SCL_PERIOD_NS = 10000;
    localparam int LDI_QTR_CYC = LDI_SCL_PERIOD_NS / (4 * LDI_CLK_SYS_NS);

    // device end receive states
    typedef enum logic [2:0] {
        LDI_DS_IDLE,
        LDI_DS_ADDR,
        LDI_DS_REG,
        LDI_DS_DATA,
        LDI_DS_ACK,
        LDI_DS_SKIP
    } ldi_dev_st_e;

    // master end sequencing states
    typedef enum logic [1:0] {
        LDI_MS_IDLE,
        LDI_MS_START,
        LDI_MS_BIT,
        LDI_MS_STOP
    } ldi_mst_st_e;

    // accept a synchronised level once two stages agree
    function automatic logic ldi_filt(input logic cur, input logic a,
                                      input logic b);
        ldi_filt = (a == b) ? a : cur;
    endfunction

endpackage

// [verilog/ldi_if.sv]
// two-wire bus carrier joining master end and device end
// assumes: both wires pulled high when nobody drives them low
`timescale 1ns/1ps
interface ldi_if;
    // master drivers
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    // device drivers
    logic d_sda_o;
    logic d_sda_oe_n;
    // resolved wire levels
    logic scl_line;
    logic sda_line;

    // wired-and with pull-up
    assign scl_line = m_scl_oe_n | m_scl_o;
    assign sda_line = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

    modport master (
        output m_scl_o,
        output m_scl_oe_n,
        output m_sda_o,
        output m_sda_oe_n,
        input sda_line
    );

    modport device (
        output d_sda_o,
        output d_sda_oe_n,
        input scl_line,
        input sda_line
    );
endinterface

// [verilog/ldi_mst.sv]
// master end: issues start, three-byte write, stop
// assumes: a pull-up on both wires; no clock stretching by the device
`timescale 1ns/1ps
module ldi_mst import ldi_pkg::*; #(
    parameter int QTR_CYC = LDI_QTR_CYC
) (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    // bus side
    ldi_if.master bus,
    // write command
    input logic cmd_valid,
    input logic [6:0] cmd_dev_addr,
    input logic [7:0] cmd_reg_addr,
    input logic [7:0] cmd_data,
    output logic cmd_ready,
    // completion
    output logic done,
    output logic nack_err
);

    ldi_mst_st_e state_reg; // sequencing state
    logic [15:0] qcnt_reg; // quarter-period counter
    logic tick; // one quarter elapsed
    logic [1:0] q_reg; // quarter within a bit
    logic [1:0] byte_reg; // byte being sent
    logic [3:0] bit_reg; // bit within byte, 8 is ack
    logic [7:0] shift_reg; // byte being shifted out
    logic [7:0] tx_reg [3]; // address, register, data
    logic [2:0] sda_s_reg; // data line synchroniser
    logic sda_f_reg; // filtered data line
    logic scl_oe_n_reg; // low while pulling clock low
    logic sda_oe_n_reg; // low while pulling data low
    logic ready_reg; // command accepted when high
    logic done_reg; // completion pulse
    logic nack_reg; // missing ack seen

    // quarter ticks, counting only during a transfer
    always_ff @(posedge clk_sys) begin
        if (!rst_n || state_reg == LDI_MS_IDLE || tick) begin
            qcnt_reg <= 16'h0000;
        end else begin
            qcnt_reg <= qcnt_reg + 16'h0001;
        end
    end
    assign tick = (qcnt_reg == 16'(QTR_CYC - 1));

    // data line back from the bus; first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        sda_s_reg <= {sda_s_reg[1:0], bus.sda_line};
        if (!rst_n) begin
            sda_f_reg <= 1'b1;
        end else begin
            sda_f_reg <= ldi_filt(sda_f_reg, sda_s_reg[1], sda_s_reg[2]);
        end
    end

    // sequencer and wire drivers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= LDI_MS_IDLE;
            q_reg <= 2'h0;
            byte_reg <= 2'h0;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                tx_reg[i] <= 8'h00;
            end
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                LDI_MS_IDLE: begin
                    if (cmd_valid) begin
                        // address byte carries the write direction
                        tx_reg[0] <= {cmd_dev_addr, LDI_DIR_WRITE}; // [R10]
                        tx_reg[1] <= cmd_reg_addr; // [R12]
                        tx_reg[2] <= cmd_data;
                        ready_reg <= 1'b0;
                        nack_reg <= 1'b0;
                        q_reg <= 2'h0;
                        state_reg <= LDI_MS_START;
                    end
                end
                LDI_MS_START: if (tick) begin
                    q_reg <= q_reg + 2'h1;
                    unique case (q_reg)
                        // data falls while clock high
                        2'h0: sda_oe_n_reg <= 1'b0; // [R04] [R02]
                        2'h1: scl_oe_n_reg <= 1'b0;
                        2'h2: shift_reg <= tx_reg[0];
                        2'h3: begin
                            byte_reg <= 2'h0;
                            bit_reg <= 4'h0;
                            state_reg <= LDI_MS_BIT;
                        end
                    endcase
                end
                LDI_MS_BIT: if (tick) begin
                    q_reg <= q_reg + 2'h1;
                    unique case (q_reg)
                        // change data only while clock low
                        2'h0: sda_oe_n_reg <= (bit_reg == LDI_ACK_SLOT) ?
                                  1'b1 : shift_reg[7]; // [R01] [R08]
                        2'h1: scl_oe_n_reg <= 1'b1;
                        2'h2: if (bit_reg == LDI_ACK_SLOT) begin
                            nack_reg <= sda_f_reg; // [R09]
                        end
                        2'h3: begin
                            scl_oe_n_reg <= 1'b0;
                            if (bit_reg != LDI_ACK_SLOT) begin
                                // msb first
                                shift_reg <= {shift_reg[6:0], 1'b0}; // [R07]
                                bit_reg <= bit_reg + 4'h1;
                            end else if (nack_reg ||
                                         byte_reg == LDI_LAST_BYTE) begin
                                state_reg <= LDI_MS_STOP;
                            end else begin
                                byte_reg <= byte_reg + 2'h1;
                                shift_reg <= tx_reg[byte_reg + 2'h1];
                                bit_reg <= 4'h0;
                            end
                        end
                    endcase
                end
                LDI_MS_STOP: if (tick) begin
                    q_reg <= q_reg + 2'h1;
                    unique case (q_reg)
                        2'h0: sda_oe_n_reg <= 1'b0;
                        2'h1: scl_oe_n_reg <= 1'b1;
                        // data rises while clock high
                        2'h2: sda_oe_n_reg <= 1'b1; // [R04] [R03]
                        2'h3: begin
                            done_reg <= 1'b1;
                            ready_reg <= 1'b1;
                            state_reg <= LDI_MS_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    // open-drain: only ever drive low
    assign bus.m_scl_o = 1'b0;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_scl_oe_n = scl_oe_n_reg;
    assign bus.m_sda_oe_n = sda_oe_n_reg;
    assign cmd_ready = ready_reg;
    assign done = done_reg;
    assign nack_err = nack_reg;

endmodule

// [tb/ldi_sva.sv]
// checker of the two-wire link between master end and device end
// assumes: clk_sys oversamples the bus wires many times per quarter
`timescale 1ns/1ps
module ldi_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // party drivers
    input wire logic m_sda_oe_n,
    input wire logic d_sda_oe_n,
    // resolved wires
    input wire logic scl_line,
    input wire logic sda_line
);
    logic scl_reg; // wire levels one cycle back
    logic sda_reg;
    logic [5:0] cnt_reg; // clock rises since last start or stop
    logic stop_seen; // data rise while clock high

    assign stop_seen = scl_line && scl_reg && !sda_reg && sda_line;

    // delayed copies of the wires
    always_ff @(posedge clk_sys) begin
        scl_reg <= rst_n ? scl_line : 1'b1;
        sda_reg <= rst_n ? sda_line : 1'b1;
    end

    // count clock pulses inside a frame
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
        end else if (stop_seen ||
                     (scl_line && scl_reg && sda_reg && !sda_line)) begin
            cnt_reg <= 6'h00; // start or stop resets the count
        end else if (scl_line && !scl_reg) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_dev_quiet;
        $changed(d_sda_oe_n) |-> !scl_line && !scl_reg;
    endproperty
    a_dev_quiet: assert property (p_dev_quiet)
        else $error("device moved data with clock high");
    property p_mst_edge;
        $changed(m_sda_oe_n) && scl_line && scl_reg
            |-> cnt_reg inside {6'h00, 6'h0a, 6'h13, 6'h1c};
    endproperty
    a_mst_edge: assert property (p_mst_edge)
        else $error("master data moved high mid byte");
    property p_ack_pull;
        $fell(d_sda_oe_n) |-> cnt_reg inside {6'd8, 6'd17, 6'd26};
    endproperty
    a_ack_pull: assert property (p_ack_pull)
        else $error("ack not after eighth bit");
    property p_ack_free;
        $rose(d_sda_oe_n) |-> cnt_reg inside {6'd9, 6'd18, 6'd27};
    endproperty
    a_ack_free: assert property (p_ack_free)
        else $error("ack not released after ninth pulse");
    property p_ack_hold;
        $rose(scl_line) && !d_sda_oe_n |-> !d_sda_oe_n [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("ack dropped in clock high");
    property p_mst_rel;
        !d_sda_oe_n && scl_line |-> m_sda_oe_n;
    endproperty
    a_mst_rel: assert property (p_mst_rel)
        else $error("master holds data in ack pulse");
    property p_frame_len;
        stop_seen |-> cnt_reg inside {6'h0a, 6'h13, 6'h1c};
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("stop inside a byte");
    property p_dir_wr;
        $rose(scl_line) && cnt_reg == 6'd7 |-> !sda_line;
    endproperty
    a_dir_wr: assert property (p_dir_wr)
        else $error("direction bit not write");
    property p_idle_rel;
        stop_seen |-> d_sda_oe_n;
    endproperty
    a_idle_rel: assert property (p_idle_rel)
        else $error("device holds data at stop");
endmodule

// [tb/tb.sv]
// bench: master end against device end, plus a bench-driven second link
// assumes: wires pulled high; inputs change by nba on clk_sys edges
`timescale 1ns/1ps
module tb import ldi_pkg::*; ;
    localparam int QC = 12; // quarter bus clock in clk_sys
    localparam logic [6:0] DA = LDI_DEF_DEV_ADDR; // both devices
    logic clk_sys, clk_link, rst_n;
    logic cmd_valid, cmd_ready, done, nack_err;
    logic [6:0] cmd_dev_addr;
    logic [7:0] cmd_reg_addr, cmd_data;
    logic pin_input_level, mf_is_input;
    logic wr_valid, pin_data, bus_busy, wr_valid2, bus_busy2;
    logic [7:0] wr_addr, wr_data, wr_addr2, wr_data2;
    int n_mismatch = 0, num_checks = 0, n_wr = 0, n_wr2 = 0;
    ldi_if bus1 ();
    ldi_if bus2 ();
    ldi_mst #(.QTR_CYC(QC)) ldi_mst_i (.clk_sys, .rst_n,
        .bus(bus1.master), .cmd_valid, .cmd_dev_addr, .cmd_reg_addr,
        .cmd_data, .cmd_ready, .done, .nack_err);
    ldi_dev #(.OWN_ADDR(DA)) ldi_dev_i (.clk_link, .bus(bus1.device),
        .clk_sys, .rst_n, .pin_input_level, .mf_is_input, .wr_valid,
        .wr_addr, .wr_data, .pin_data, .bus_busy);
    ldi_dev #(.OWN_ADDR(DA)) ldi_dev_i2 (.clk_link, .bus(bus2.device),
        .clk_sys, .rst_n, .pin_input_level, .mf_is_input,
        .wr_valid(wr_valid2), .wr_addr(wr_addr2), .wr_data(wr_data2),
        .pin_data(), .bus_busy(bus_busy2));
    ldi_sva ldi_sva_i (.clk_sys, .rst_n, .m_sda_oe_n(bus1.m_sda_oe_n),
        .d_sda_oe_n(bus1.d_sda_oe_n), .scl_line(bus1.scl_line),
        .sda_line(bus1.sda_line));

    // clocks, link clock offset in phase
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #3.3;
        forever #7.5 clk_link = ~clk_link;
    end

    // count committed writes of both devices
    always @(posedge clk_sys) begin
        if (wr_valid === 1'b1) n_wr++;
        if (wr_valid2 === 1'b1) n_wr2++;
    end

    task automatic chk(input logic [7:0] got, exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one command through the master end, judged at done
    task automatic send(input logic [6:0] a, input logic [7:0] r, d,
                        input logic ok);
        int k;
        int w0;
        w0 = n_wr;
        k = 0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_dev_addr <= a;
        cmd_reg_addr <= r;
        cmd_data <= d;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        while (done !== 1'b1 && k < 3000) begin
            @(posedge clk_sys);
            k++;
            if (k == 200) chk(bus_busy, 1'b1, "not busy");
            if (k == 200) chk(cmd_ready, 1'b0, "ready in transfer");
        end
        if (k >= 3000) chk(1'b0, 1'b1, "no done");
        chk(cmd_ready, 1'b1, "ready at done");
        chk(nack_err, !ok, "ack result");
        chk(8'(n_wr - w0), ok, "write count");
        if (ok) begin
            chk(wr_addr, r, "register select");
            chk(wr_data, d, "register data");
        end
        repeat (8) @(posedge clk_sys);
        chk(bus_busy, 1'b0, "busy after stop");
    endtask

    // bench-driven wire levels held one quarter
    task automatic bb(input logic c, input logic s);
        bus2.m_scl_oe_n <= c;
        bus2.m_sda_oe_n <= s;
        repeat (QC) @(posedge clk_sys);
    endtask
    task automatic bbit(input logic v, output logic s);
        bb(1'b0, v);
        bb(1'b1, v);
        s = bus2.sda_line;
        bb(1'b1, v);
        bb(1'b0, v);
    endtask
    task automatic bbyte(input logic [7:0] b, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bbit(b[i], s);
            chk(s, b[i], "data bit on wire");
        end
        bbit(1'b1, s);
        chk(s, !ack, "ack slot");
    endtask
    task automatic bstart();
        bb(1'b0, 1'b1);
        bb(1'b1, 1'b1);
        bb(1'b1, 1'b0);
        bb(1'b0, 1'b0);
    endtask
    task automatic bstop();
        bb(1'b0, 1'b0);
        bb(1'b1, 1'b0);
        bb(1'b1, 1'b1);
        repeat (10) @(posedge clk_sys);
    endtask

    // writes back to back, pin copy checked per row
    task automatic t_writes();
        logic [18:0] t [4];
        t = '{{3'h7, 16'h10ff}, {3'h1, 16'h2000},
              {3'h4, 16'hc0a5}, {3'h2, 16'hff5a}};
        foreach (t[i]) begin
            mf_is_input <= t[i][18];
            pin_input_level <= t[i][17];
            send(DA, t[i][15:8], t[i][7:0], 1'b1);
            chk(pin_data, t[i][16], "pin copy");
        end
    endtask

    // foreign address: no ack, no write, pin untouched
    task automatic t_foreign();
        mf_is_input <= 1'b1;
        pin_input_level <= 1'b1;
        send(DA ^ 7'h01, 8'h10, 8'h77, 1'b0);
        chk(pin_data, 1'b0, "pin on foreign");
    endtask

    // cut data byte, restart, full write; then a read
    task automatic t_rstart();
        int w0;
        logic s;
        w0 = n_wr2;
        bstart();
        chk(bus_busy2, 1'b1, "busy after start");
        bbyte({DA, LDI_DIR_WRITE}, 1'b1);
        bbyte(8'h33, 1'b1);
        for (int i = 0; i < 4; i++) bbit(1'b1, s);
        bstart();
        bbyte({DA, LDI_DIR_WRITE}, 1'b1);
        bbyte(8'h44, 1'b1);
        bbyte(8'h3c, 1'b1);
        bstop();
        chk(bus_busy2, 1'b0, "idle after stop");
        chk(8'(n_wr2 - w0), 8'h01, "restart writes");
        chk(wr_addr2, 8'h44, "restart select");
        chk(wr_data2, 8'h3c, "restart data");
        bstart();
        bbyte({DA, LDI_DIR_READ}, 1'b1);
        bbyte(8'hff, 1'b0);
        bstop();
        chk(8'(n_wr2 - w0), 8'h01, "read wrote");
    endtask

    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_dev_addr = 7'h00;
        cmd_reg_addr = 8'h00;
        cmd_data = 8'h00;
        pin_input_level = 1'b0;
        mf_is_input = 1'b0;
        bus2.m_scl_o = 1'b0;
        bus2.m_sda_o = 1'b0;
        bus2.m_scl_oe_n = 1'b1;
        bus2.m_sda_oe_n = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        t_writes();
        t_foreign();
        t_rstart();
        print_verdict();
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
endmodule
